/* File: sabc_pkg.sv */
// Package of command codes, bank states and timing counts for the bank engine.
package sabc_pkg;
  // Command codes formed from {ras_n, cas_n, we_n} with chip select low.
  localparam logic [2:0] SABC_CMD_ACT = 3'h3;
  localparam logic [2:0] SABC_CMD_RD = 3'h5;
  localparam logic [2:0] SABC_CMD_WR = 3'h4;
  localparam logic [2:0] SABC_CMD_PRE = 3'h2;
  localparam logic [2:0] SABC_CMD_BST = 3'h6;
  localparam logic [2:0] SABC_CMD_NOP = 3'h7;
  localparam logic [2:0] SABC_CMD_REF = 3'h1;
  localparam logic [2:0] SABC_CMD_LMR = 3'h0;
  // Address bit that carries the auto precharge request.
  localparam int SABC_AP_BIT = 10;
  // Timing figures in nanoseconds and the clock period.
  localparam int SABC_CLK_NS = 10;
  localparam int SABC_PRECHARGE_PERIOD_NS = 20;
  localparam int SABC_ACT_TO_ACCESS_NS = 20;
  localparam int SABC_WRITE_RECOVERY_NS = 15;
  localparam int SABC_SELF_REFRESH_EXIT_NS = 80;
  // Least times round up to whole cycles, never below one.
  localparam int SABC_RP_CYC = (SABC_PRECHARGE_PERIOD_NS + SABC_CLK_NS - 1)
                               / SABC_CLK_NS;
  localparam int SABC_RCD_CYC = (SABC_ACT_TO_ACCESS_NS + SABC_CLK_NS - 1)
                                / SABC_CLK_NS;
  localparam int SABC_WR_CYC = (SABC_WRITE_RECOVERY_NS + SABC_CLK_NS - 1)
                               / SABC_CLK_NS;
  localparam int SABC_XSR_CYC = (SABC_SELF_REFRESH_EXIT_NS + SABC_CLK_NS - 1)
                                / SABC_CLK_NS;
  // Default read latency and burst length in clocks.
  localparam int SABC_READ_LATENCY = 3;
  localparam int SABC_BURST_LEN = 4;
  localparam int SABC_BANKS = 4;
  localparam logic [3:0] SABC_CNT_ZERO = 4'h0;
  // Per bank state, Gray coded along idle, activating, active, burst.
  typedef enum logic [2:0] {
    SABC_IDLE = 3'h0,
    SABC_ACTIVATING = 3'h1,
    SABC_ACTIVE = 3'h3,
    SABC_READ = 3'h2,
    SABC_WRITE = 3'h6,
    SABC_READ_AP = 3'h7,
    SABC_WRITE_AP = 3'h5,
    SABC_PRECHARGING = 3'h4
  } sabc_bank_st_t;
endpackage : sabc_pkg

/* File: sabc_fifo.sv */
// Synchronous valid/ready FIFO that carries read data toward the pins.
`timescale 1ns/1ns
`default_nettype none
module sabc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } sabc_fifo_st_t;
  sabc_fifo_st_t st_q;
  sabc_fifo_st_t st_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic full;
  logic empty;

  // Full when pointers differ only in the wrap bit.
  assign empty = (st_q.wr_ptr == st_q.rd_ptr);
  assign full = (st_q.wr_ptr[AW] != st_q.rd_ptr[AW]) &&
                (st_q.wr_ptr[AW-1:0] == st_q.rd_ptr[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_q[st_q.rd_ptr[AW-1:0]];

  // Pointer advance on each accepted push and pop.
  always_comb begin
    st_d = st_q;
    if (in_valid && !full) begin
      st_d.wr_ptr = st_q.wr_ptr + 1'b1;
    end
    if (out_ready && !empty) begin
      st_d.rd_ptr = st_q.rd_ptr + 1'b1;
    end
  end

  // Pointer registers.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Storage array, written without reset.
  always_ff @(posedge clk_sys) begin
    if (in_valid && !full) begin
      mem_q[st_q.wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule : sabc_fifo
`default_nettype wire

/* File: sabc_bank_engine.sv */
// Multi-bank command engine with alternate-bank burst interruption.
// Contract
// - Deselect or no-op leaves banks unchanged.
// - Decode activate, read, write, precharge line levels.
// - Idle after precharge period; active after delay.
// - Plain burst state lasts until end or cut.
// - Auto-precharge state ends after precharge period.
// - Burst terminate hits only a bank in a plain burst.
// - Both auto-precharge variants interrupt alike.
// - Cut auto-precharge burst precharges itself.
// - Other-bank precharge leaves burst running.
// - Read-after-read switches data after read latency.
// - Write ends read burst when registered.
// - Read ends write; last data clock before.
// - Write ends write; last data clock before.
// - Read cuts read-AP; precharge starts then.
// - Write cuts read-AP; precharge starts then.
// - Read cuts write-AP; recovery then precharge.
// - Write cuts write-AP; recovery then precharge.
`timescale 1ns/1ns
`default_nettype none
module sabc_bank_engine
  import sabc_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int FIFO_DEPTH = 16,
  parameter int BURST_LEN = sabc_pkg::SABC_BURST_LEN,
  parameter int READ_LATENCY = sabc_pkg::SABC_READ_LATENCY
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Command pins.
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bank_addr,
  input wire logic [11:0] addr,
  input wire logic self_refresh_exit,
  // Data pins.
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic dqm,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  // Storage side: write words leave here, read words arrive here.
  output logic wr_valid,
  output logic [1:0] wr_bank,
  output logic [DATA_W-1:0] wr_data,
  input wire logic [DATA_W-1:0] rd_word,
  // State view per bank and error flag.
  output logic [3*SABC_BANKS-1:0] bank_state,
  output logic illegal_cmd
);
  import sabc_pkg::*;

  localparam int LW = 4;
  localparam logic [LW-1:0] RP_C = LW'(SABC_RP_CYC);
  localparam logic [LW-1:0] RCD_C = LW'(SABC_RCD_CYC);
  localparam logic [LW-1:0] WR_C = LW'(SABC_WR_CYC);
  localparam logic [LW-1:0] BL_C = LW'(BURST_LEN);
  localparam logic [LW-1:0] XSR_C = LW'(SABC_XSR_CYC);

  typedef struct packed {
    sabc_bank_st_t st;
    logic [LW-1:0] timer;   // Precharge, activate or recovery countdown.
    logic [LW-1:0] left;    // Burst words remaining.
    logic rec;              // Write recovery running before precharge.
  } sabc_bank_t;

  typedef struct packed {
    sabc_bank_t [SABC_BANKS-1:0] bank;
    logic cke_prev;
    logic [LW-1:0] xsr;
    logic [READ_LATENCY-1:0] rd_pipe; // Read word slots in flight.
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
    logic wr_valid;
    logic [1:0] wr_bank;
    logic [DATA_W-1:0] wr_data;
    logic [3*SABC_BANKS-1:0] view;
    logic illegal;
  } sabc_state_t;

  sabc_state_t s_q;
  sabc_state_t s_d;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;

  // Returns true when the bank holds a burst of any kind.
  function automatic logic sabc_bursting(input sabc_bank_st_t st);
    return st == SABC_READ || st == SABC_WRITE ||
           st == SABC_READ_AP || st == SABC_WRITE_AP;
  endfunction : sabc_bursting

  // Returns true when the bank holds a write burst of any kind with words still left.
  function automatic logic sabc_writing(input sabc_bank_t b);
    return (b.st == SABC_WRITE || b.st == SABC_WRITE_AP) &&
           b.left != SABC_CNT_ZERO;
  endfunction : sabc_writing

  // Read data leaves through the buffer; a full buffer drops a word.
  // The drain side is always ready, so the buffer only fills when the
  // read slots outrun the drain, which a legal command stream cannot do.
  // A user who stalls the drain must size the depth to cover a burst.
  sabc_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) i_sabc_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(s_q.rd_pipe[0]),
    .in_ready(fifo_in_ready),
    .in_data(rd_word),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1),
    .out_data(fifo_out_data)
  );

  // Next state: command decode, per bank trackers and data paths.
  // Write data timing follows the command pins directly.
  // The first word of a write burst is registered with the write command
  // itself, so a new write takes its own word at the edge that starts it.
  // The remaining words are taken on the following edges, one per clock,
  // while the burst counter is still running.
  // An interrupting read or write to any bank blocks the old burst's word
  // at the interrupting edge, so the old bank's last word is the one
  // registered on the clock before.
  // The data mask blocks a word at any edge; the burst counter still
  // advances, so a masked word is simply lost, not deferred.
  // Read slots are queued one read latency deep; a write command empties
  // the queue so that no read word meets write data on the bus.
  // Per bank trackers run side by side, and only the bank named by the
  // bank address sees an activate, read, write or precharge; every other bank
  // sees only a burst terminate or the effect of an interrupt on its own burst.
  // Hazard: a refresh or mode load with any bank open is flagged and
  // otherwise ignored, so no bank state is disturbed by it.
  always_comb begin
    logic valid_edge;
    logic sel;
    logic [2:0] cmd;
    logic is_act;
    logic is_rd;
    logic is_wr;
    logic is_pre;
    logic is_bst;
    logic is_glob;
    logic ap;
    logic all_idle;
    logic any_wr;
    logic [1:0] wb;
    valid_edge = 1'b0;
    sel = 1'b0;
    cmd = SABC_CMD_NOP;
    is_act = 1'b0;
    is_rd = 1'b0;
    is_wr = 1'b0;
    is_pre = 1'b0;
    is_bst = 1'b0;
    is_glob = 1'b0;
    ap = 1'b0;
    all_idle = 1'b1;
    any_wr = 1'b0;
    wb = 2'h0;
    s_d = s_q;
    s_d.cke_prev = cke;
    s_d.illegal = 1'b0;
    s_d.wr_valid = 1'b0;
    // Self refresh exit blocks commands until the exit time passes.
    if (self_refresh_exit) begin
      s_d.xsr = XSR_C;
    end else if (s_q.xsr != SABC_CNT_ZERO) begin
      s_d.xsr = s_q.xsr - 1'b1;
    end
    valid_edge = s_q.cke_prev && cke && s_q.xsr == SABC_CNT_ZERO;
    // Deselect and no-op decode to nothing at all.
    sel = valid_edge && !cs_n;
    cmd = {ras_n, cas_n, we_n};
    is_act = sel && cmd == SABC_CMD_ACT;
    is_rd = sel && cmd == SABC_CMD_RD;
    is_wr = sel && cmd == SABC_CMD_WR;
    is_pre = sel && cmd == SABC_CMD_PRE;
    is_bst = sel && cmd == SABC_CMD_BST;
    is_glob = sel && (cmd == SABC_CMD_REF || cmd == SABC_CMD_LMR);
    ap = addr[SABC_AP_BIT];
    // Find the write burst that owns write data this cycle.
    for (int i = 0; i < SABC_BANKS; i++) begin
      if (s_q.bank[i].st != SABC_IDLE) begin
        all_idle = 1'b0;
      end
      if (sabc_writing(s_q.bank[i])) begin
        any_wr = 1'b1;
        wb = 2'(i);
      end
    end
    // Global commands with a bank still open are flagged.
    if (is_glob && !all_idle) begin
      s_d.illegal = 1'b1;
    end
    // Write data is taken only up to the clock before an interrupt.
    if (any_wr && !dqm && !(is_rd || is_wr)) begin
      s_d.wr_valid = 1'b1;
      s_d.wr_bank = wb;
      s_d.wr_data = dq_in;
    end
    // Bank trackers, one per bank.
    for (int i = 0; i < SABC_BANKS; i++) begin
      sabc_bank_t b;
      logic mine;
      b = s_q.bank[i];
      mine = bank_addr == 2'(i);
      if (b.timer != SABC_CNT_ZERO) begin
        b.timer = b.timer - 1'b1;
      end
      if (b.left != SABC_CNT_ZERO) begin
        b.left = b.left - 1'b1;
      end
      // Timed transitions.
      unique case (b.st)
        SABC_ACTIVATING: begin
          if (b.timer == SABC_CNT_ZERO) b.st = SABC_ACTIVE;
        end
        SABC_PRECHARGING: begin
          if (b.timer == SABC_CNT_ZERO) b.st = SABC_IDLE;
        end
        SABC_READ, SABC_WRITE: begin
          if (b.left == SABC_CNT_ZERO) b.st = SABC_ACTIVE;
        end
        SABC_READ_AP, SABC_WRITE_AP: begin
          // Write-AP burst end or cut starts recovery, then precharge; read-AP burst end precharges at once.
          if (b.left == SABC_CNT_ZERO && b.timer == SABC_CNT_ZERO) begin
            if (b.rec || b.st == SABC_READ_AP) begin
              b.st = SABC_PRECHARGING;
              b.timer = RP_C;
              b.rec = 1'b0;
            end else begin
              b.rec = 1'b1;
              b.timer = WR_C;
            end
          end
        end
        default: ;
      endcase
      // Commands aimed at this bank.
      if (mine && is_act) begin
        if (b.st == SABC_IDLE) begin
          b.st = SABC_ACTIVATING;
          b.timer = RCD_C;
        end else begin
          s_d.illegal = 1'b1;
        end
      end else if (mine && (is_rd || is_wr)) begin
        if (b.st == SABC_ACTIVE || b.st == SABC_READ || b.st == SABC_WRITE)
        begin
          b.st = is_rd ? (ap ? SABC_READ_AP : SABC_READ)
                       : (ap ? SABC_WRITE_AP : SABC_WRITE);
          // A write's first word is taken now, so one word fewer remains.
          b.left = is_wr ? BL_C - 1'b1 : BL_C;
          b.rec = 1'b0;
          // The new write's own word goes out with the command edge.
          if (is_wr && !dqm) begin
            s_d.wr_valid = 1'b1;
            s_d.wr_bank = 2'(i);
            s_d.wr_data = dq_in;
          end
        end else begin
          s_d.illegal = 1'b1;
        end
      end else if (mine && is_pre) begin
        if (b.st == SABC_ACTIVE || b.st == SABC_READ || b.st == SABC_WRITE)
        begin
          b.st = SABC_PRECHARGING;
          b.timer = RP_C;
          b.left = SABC_CNT_ZERO;
        end
      end else if ((is_rd || is_wr) && sabc_bursting(b.st)) begin
        // Another bank's burst cuts this one, AP or not alike.
        b.left = SABC_CNT_ZERO;
        unique case (b.st)
          SABC_READ, SABC_WRITE: b.st = SABC_ACTIVE;
          SABC_READ_AP: begin
            b.st = SABC_PRECHARGING;
            b.timer = RP_C;
          end
          default: begin
            b.rec = 1'b1;
            b.timer = WR_C;
          end
        endcase
      end
      // Other-bank precharge does not touch a running burst.
      // Burst terminate stops only a bank holding a plain read or write burst.
      if (is_bst && (b.st == SABC_READ || b.st == SABC_WRITE)) begin
        b.st = SABC_ACTIVE;
        b.left = SABC_CNT_ZERO;
      end
      s_d.bank[i] = b;
      s_d.view[3*i +: 3] = b.st;
    end
    // Read data emerges one read latency after each read slot.
    s_d.rd_pipe = {1'b0, s_q.rd_pipe[READ_LATENCY-1:1]};
    for (int i = 0; i < SABC_BANKS; i++) begin
      if ((s_d.bank[i].st == SABC_READ || s_d.bank[i].st == SABC_READ_AP)
          && s_d.bank[i].left != SABC_CNT_ZERO) begin
        s_d.rd_pipe[READ_LATENCY-1] = 1'b1;
      end
    end
    // A new read replaces the old data, and a write silences it.
    if (is_wr) begin
      s_d.rd_pipe = '0;
    end
    s_d.dq_oe = fifo_out_valid && !dqm;
    s_d.dq_out = fifo_out_data;
  end

  // State register.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign dq_out = s_q.dq_out;
  assign dq_oe = s_q.dq_oe;
  assign wr_valid = s_q.wr_valid;
  assign wr_bank = s_q.wr_bank;
  assign wr_data = s_q.wr_data;
  assign bank_state = s_q.view;
  assign illegal_cmd = s_q.illegal;
endmodule : sabc_bank_engine
`default_nettype wire

/* File: sabc_bank_engine_sva.sv */
// Concurrent checks on the ports of the multi-bank command engine.
`timescale 1ns/1ns
`default_nettype none
module sabc_bank_engine_chk
  import sabc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Command pins.
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bank_addr,
  input wire logic [11:0] addr,
  input wire logic self_refresh_exit,
  // Observed state.
  input wire logic [3*SABC_BANKS-1:0] bank_state,
  input wire logic illegal_cmd
);
  logic ckp_q;
  logic [3:0] xw_q;
  logic take;
  logic [2:0] cmd;
  logic [2:0] bs0;
  logic [2:0] bs1;
  // Clock enable history and the self refresh exit wait.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ckp_q <= 1'b0;
      xw_q <= 4'h0;
    end else begin
      ckp_q <= cke;
      if (self_refresh_exit) xw_q <= 4'h8;
      else if (xw_q != 4'h0) xw_q <= xw_q - 4'h1;
    end
  end
  // A command counts only on an edge where the device takes it.
  assign take = cke && ckp_q && !cs_n && (xw_q == 4'h0);
  assign cmd = {ras_n, cas_n, we_n};
  assign bs0 = bank_state[2:0];
  assign bs1 = bank_state[5:3];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_desel; cs_n |=> !illegal_cmd; endproperty
  a_desel: assert property (p_desel) else $error("deselect flagged");
  property p_act; take && cmd == SABC_CMD_ACT && bank_addr == 2'h0 &&
    bs0 == SABC_IDLE |=> bs0 == SABC_ACTIVATING; endproperty
  a_act: assert property (p_act) else $error("activate missed");
  property p_rcd; bs0 == SABC_ACTIVATING |-> ##[1:2] bs0 == SABC_ACTIVE;
  endproperty
  a_rcd: assert property (p_rcd) else $error("row never active");
  property p_rp; bs0 == SABC_PRECHARGING |-> ##[1:4] bs0 == SABC_IDLE;
  endproperty
  a_rp: assert property (p_rp) else $error("precharge never ends");
  property p_ap; take && cmd == SABC_CMD_WR && bank_addr == 2'h0 &&
    bs0 == SABC_ACTIVE && addr[SABC_AP_BIT] |=> bs0 == SABC_WRITE_AP;
  endproperty
  a_ap: assert property (p_ap) else $error("auto precharge lost");
  property p_wcut; take && cmd == SABC_CMD_WR && bank_addr == 2'h1 &&
    bs0 == SABC_WRITE |=> bs0 == SABC_ACTIVE; endproperty
  a_wcut: assert property (p_wcut) else $error("write not cut");
  property p_ref; take && cmd == SABC_CMD_REF && bank_state != '0
    |=> illegal_cmd; endproperty
  a_ref: assert property (p_ref) else $error("refresh not refused");
  property p_cke; !cke && bs0 == SABC_IDLE |=> bs0 == SABC_IDLE; endproperty
  a_cke: assert property (p_cke) else $error("taken without cke");
  property p_pre; take && cmd == SABC_CMD_PRE && bank_addr == 2'h0 &&
    bs1 == SABC_READ && $past(bs1) != SABC_READ |=> bs1 == SABC_READ;
  endproperty
  a_pre: assert property (p_pre) else $error("burst disturbed");
endmodule : sabc_bank_engine_chk
bind sabc_bank_engine sabc_bank_engine_chk i_sabc_bank_engine_chk (
  .clk_sys(clk_sys), .reset(reset), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
  .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr), .addr(addr),
  .self_refresh_exit(self_refresh_exit), .bank_state(bank_state),
  .illegal_cmd(illegal_cmd));
`default_nettype wire

/* File: sabc_ctrl_model.sv */
// Behavioural memory controller that drives command and data pins.
`timescale 1ns/1ns
`default_nettype none
module sabc_ctrl_model
  import sabc_pkg::*;
(
  // Clock.
  input wire logic clk_sys,
  // Command pins.
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] bank_addr,
  output logic [11:0] addr,
  // Write data pins.
  output logic [15:0] dq_in,
  output logic dqm
);
  // Pins start deselected with clock enable high.
  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = SABC_CMD_NOP;
    bank_addr = 2'h0;
    addr = 12'h000;
    dq_in = 16'h0000;
    dqm = 1'b0;
  end
  // One command a clock, changed just after the rising edge.
  // Callers also issue refused commands, such as a refresh with banks open.
  task automatic drive(input logic ck, input logic cs, input logic [2:0] c,
    input logic [1:0] b, input logic ap, input logic [15:0] d,
    input logic dv, input logic m);
    @(posedge clk_sys);
    #1;
    cke = ck;
    cs_n = cs;
    {ras_n, cas_n, we_n} = c;
    bank_addr = b;
    addr = {1'b0, ap, 10'h000};
    dq_in = dv ? d : ~dq_in; // Released data shows the inverse.
    dqm = m;
  endtask : drive
endmodule : sabc_ctrl_model
`default_nettype wire

/* File: sdram_alternate_bank_command_rules_test.sv */
// Self-checking bench for the multi-bank command engine.
`timescale 1ns/1ns
`default_nettype none
module sdram_alternate_bank_command_rules_test;
  import sabc_pkg::*;
  logic clk_sys, reset, self_refresh_exit, cke, cs_n, ras_n, cas_n, we_n;
  logic dqm, dq_oe, wr_valid, illegal_cmd;
  logic [1:0] bank_addr, wr_bank;
  logic [11:0] addr, bank_state;
  logic [15:0] dq_in, dq_out, wr_data, rd_word;
  logic [17:0] exp_q[$];
  int num_errors = 0;
  int total_checks = 0;
  int seed = 32'h0000_78a0;
  // Free running system clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  sabc_bank_engine i_sabc_bank_engine (.clk_sys(clk_sys), .reset(reset),
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_addr(bank_addr), .addr(addr),
    .self_refresh_exit(self_refresh_exit), .dq_in(dq_in), .dqm(dqm),
    .dq_out(dq_out), .dq_oe(dq_oe), .wr_valid(wr_valid), .wr_bank(wr_bank),
    .wr_data(wr_data), .rd_word(rd_word), .bank_state(bank_state),
    .illegal_cmd(illegal_cmd));
  sabc_ctrl_model i_sabc_ctrl_model (.clk_sys(clk_sys), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_addr(bank_addr), .addr(addr), .dq_in(dq_in), .dqm(dqm));
  // Counts one comparison and reports a mismatch.
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Issues one command and notes the write word it should deliver.
  task automatic cm(input logic [2:0] c, input logic [1:0] b,
    input logic ap, input logic dv);
    logic [15:0] d;
    d = 16'($random(seed));
    i_sabc_ctrl_model.drive(1'b1, 1'b0, c, b, ap, d, dv, 1'b0);
    if (dv) exp_q.push_back({b, d});
  endtask : cm
  // Prints the counts and the verdict, then stops.
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  // Takes the oldest note whenever a write word appears; a read word is checked against rd_word.
  always @(posedge clk_sys) begin
    #2;
    if (wr_valid === 1'b1) begin
      chk({wr_bank, wr_data}, exp_q.size() ? exp_q.pop_front() : 18'hx);
    end
    if (dq_oe === 1'b1) chk(18'(dq_out), 18'(rd_word));
  end
  // Cuts a hung run short.
  initial begin
    #5000;
    num_errors++;
    summarize();
  end
  // Main sequence.
  initial begin
    reset = 1'b1;
    self_refresh_exit = 1'b0;
    rd_word = 16'h0000;
    repeat (2) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    rd_word = 16'($random(seed));
    chk(18'(bank_state), 18'h0_0000);
    self_refresh_exit = 1'b1;
    @(posedge clk_sys);
    #1;
    self_refresh_exit = 1'b0;
    repeat (10) cm(SABC_CMD_NOP, 2'h0, 1'b0, 1'b0);
    repeat (4) i_sabc_ctrl_model.drive(1'b1, 1'b1, 3'($random(seed)), 2'h0,
      1'b0, 16'h0000, 1'b0, 1'b0);
    i_sabc_ctrl_model.drive(1'b0, 1'b0, SABC_CMD_ACT, 2'h0, 1'b0, 16'h0000,
      1'b0, 1'b0);
    repeat (3) cm(SABC_CMD_NOP, 2'h0, 1'b0, 1'b0);
    chk(18'(bank_state), 18'h0_0000);
    cm(SABC_CMD_ACT, 2'h0, 1'b0, 1'b0);
    cm(SABC_CMD_ACT, 2'h1, 1'b0, 1'b0);
    repeat (4) cm(SABC_CMD_NOP, 2'h0, 1'b0, 1'b0);
    chk(18'(bank_state[5:0]), 18'({SABC_ACTIVE, SABC_ACTIVE}));
    cm(SABC_CMD_REF, 2'h0, 1'b0, 1'b0);
    cm(SABC_CMD_NOP, 2'h0, 1'b0, 1'b0);
    chk(18'(illegal_cmd), 18'h0_0001);
    // Plain write in bank 0 cut after two words by a write to bank 1.
    cm(SABC_CMD_WR, 2'h0, 1'b0, 1'b1);
    cm(SABC_CMD_NOP, 2'h0, 1'b0, 1'b1);
    cm(SABC_CMD_WR, 2'h1, 1'b0, 1'b1);
    cm(SABC_CMD_NOP, 2'h1, 1'b0, 1'b1);
    chk(18'(bank_state[5:0]), 18'({SABC_WRITE, SABC_ACTIVE}));
    repeat (2) cm(SABC_CMD_NOP, 2'h1, 1'b0, 1'b1);
    repeat (3) cm(SABC_CMD_NOP, 2'h0, 1'b0, 1'b0);
    chk(18'(bank_state[5:3]), 18'(SABC_ACTIVE));
    // Auto precharge write in bank 0 cut by a read to bank 1.
    cm(SABC_CMD_WR, 2'h0, 1'b1, 1'b1);
    cm(SABC_CMD_NOP, 2'h0, 1'b0, 1'b1);
    cm(SABC_CMD_RD, 2'h1, 1'b0, 1'b0);
    cm(SABC_CMD_PRE, 2'h0, 1'b0, 1'b0);
    cm(SABC_CMD_NOP, 2'h0, 1'b0, 1'b0);
    chk(18'(bank_state[5:3]), 18'(SABC_READ));
    repeat (10) cm(SABC_CMD_NOP, 2'h0, 1'b0, 1'b0);
    chk(18'(bank_state[5:0]), 18'({SABC_ACTIVE, SABC_IDLE}));
    chk(18'(exp_q.size()), 18'h0_0000);
    summarize();
  end
endmodule : sdram_alternate_bank_command_rules_test
`default_nettype wire
